// file: verilog/sas_pkg.sv
// Shared constants for the successive-approximation converter sequencer.
package sas_pkg;

    // ---------------------------------------------------------------
    // Register map and bus
    // ---------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  MODE_OFS       = 8'h00;
    localparam logic [7:0]  CHAN_OFS       = 8'h04;
    localparam logic [7:0]  WIDE_OFS       = 8'h08;
    localparam logic [7:0]  NARROW_OFS     = 8'h0C;
    localparam logic [7:0]  STATUS_OFS     = 8'h10;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int          MODE_CE_BIT    = 0;
    localparam int          MODE_TIME_LSB  = 1;
    localparam int          MODE_TIME_W    = 6;
    localparam int          MODE_START_BIT = 7;
    localparam int          CHAN_W         = 3;
    localparam int          STAT_DONE_BIT  = 0;
    localparam int          STAT_BUSY_BIT  = 1;

    // ---------------------------------------------------------------
    // Reset values and conversion shape
    // ---------------------------------------------------------------
    localparam logic [7:0]  MODE_RST       = 8'h00;
    localparam logic [2:0]  CHAN_RST       = 3'h0;
    localparam logic [15:0] WIDE_RST       = 16'h0000;
    localparam logic [7:0]  NARROW_RST     = 8'h00;
    localparam int          RES_W          = 10;
    localparam int          JUSTIFY_SHIFT  = 6;
    localparam logic [9:0]  FIRST_TRIAL    = 10'h200;
    localparam logic [3:0]  MSB_IDX        = 4'h9;

    // ---------------------------------------------------------------
    // Phase timing defaults, in clock cycles
    // ---------------------------------------------------------------
    localparam int          CNT_W          = 8;
    localparam logic [7:0]  SAMP_BASE      = 8'h08;
    localparam logic [7:0]  SAMP_STEP      = 8'h04;
    localparam logic [7:0]  CMP_BASE       = 8'h04;
    localparam logic [7:0]  CMP_STEP       = 8'h02;

endpackage

// file: verilog/sas_timing_lut.sv
// Lookup of sampling and comparison phase lengths per conversion-time code.
`timescale 1ns/100ps

module sas_timing_lut #(
    parameter logic [7:0] SAMP_BASE = sas_pkg::SAMP_BASE,
    parameter logic [7:0] SAMP_STEP = sas_pkg::SAMP_STEP,
    parameter logic [7:0] CMP_BASE  = sas_pkg::CMP_BASE,
    parameter logic [7:0] CMP_STEP  = sas_pkg::CMP_STEP
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic [5:0] i_time_code,
    output logic      [7:0] o_samp_cycles,
    output logic      [7:0] o_cmp_cycles
);

    logic [15:0] rom [64];

    // ---------------------------------------------------------------
    // Table contents: frequency bits scale sampling, level bits scale comparison.
    // ---------------------------------------------------------------
    for (genvar g = 0; g < 64; g++) begin : g_entry
        localparam logic [3:0] FREQ = 4'(g >> 2);
        localparam logic [1:0] LVL  = 2'(g);
        assign rom[g] = {8'(SAMP_BASE + 8'(FREQ) * SAMP_STEP), 8'(CMP_BASE + 8'(LVL) * CMP_STEP)};
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_samp_cycles <= SAMP_BASE;
            o_cmp_cycles  <= CMP_BASE;
        end else begin
            o_samp_cycles <= rom[i_time_code][15:8];
            o_cmp_cycles  <= rom[i_time_code][7:0];
        end
    end

endmodule // sas_timing_lut

// file: verilog/sas_sequencer.sv
// Register slave and sequencer of the ten-bit successive-approximation converter.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps

// What this block does
// - Comparator enable, mode bit 0, powers the comparator up.
// - Mode bits 6 to 1 select conversion time: frequency and level bits.
// - One input converted at a time, chosen by channel bits 2 to 0.
// - Writing one to mode bit 7 starts conversion of the selected channel.
// - Fixed sampling phase first, then hold until all decisions end.
// - First trial sets bit 9 and selects the half-reference tap.
// - Bit 9 stays one if input is at least half reference, else cleared.
// - Bit 8 trial uses quarter or three-quarter tap; kept when input at least tap.
// - Trial and decide continues down to bit 0: ten comparisons.
// - After tenth decision result is latched and interrupt raised together.
// - Next conversion starts at once while the start bit stays one.
// - Channel write aborts conversion; restarts from sampling if start is one.
// - Clearing start halts at once; results keep the last completed value.
// - Reset clears wide result to 0000 and narrow result to 00.
// - Wide result is the ten-bit value times 64; narrow holds eight bits.
// - After a channel change the next interrupt follows one conversion time.
// - Only single-channel select operation; no scanning.
// - Channel register resets to zero; codes 6 and 7 prohibited.
// - A result read coinciding with result update returns the old value.
// - Mode or channel write at conversion end blocks store and interrupt.
// - Channel writes do not clear the done flag; only software does.
module sas_sequencer #(
    parameter logic [7:0] SAMP_BASE = sas_pkg::SAMP_BASE,
    parameter logic [7:0] SAMP_STEP = sas_pkg::SAMP_STEP,
    parameter logic [7:0] CMP_BASE  = sas_pkg::CMP_BASE,
    parameter logic [7:0] CMP_STEP  = sas_pkg::CMP_STEP
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst,
    input  wire logic [sas_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [31:0]                i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    output logic [1:0]                      o_bresp,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    input  wire logic [sas_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    output logic [31:0]                     o_rdata,
    output logic [1:0]                      o_rresp,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    input  wire logic                       i_comp_ge,
    output logic                            o_comparator_enable,
    output logic                            o_sample_en,
    output logic [2:0]                      o_channel_select,
    output logic [9:0]                      o_tap_code,
    output logic                            o_done_irq
);

    typedef enum logic [1:0] {
        SAS_IDLE    = 2'b00,
        SAS_SAMPLE  = 2'b01,
        SAS_COMPARE = 2'b10
    } sas_phase_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [2:0]  chan;
        logic [15:0] wide;
        logic [7:0]  narrow;
        logic        flag;
        sas_phase_t  phase;
        logic [7:0]  cnt;
        logic [3:0]  bit_idx;
        logic [9:0]  approximation_register;
        logic        cmp_s1;
        logic        cmp_s2;
        logic        cmp_s3;
        logic        cmp;
        logic        irq;
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        w_held;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sas_state_t;

    sas_state_t s_r;
    sas_state_t s_nxt;
    logic [7:0] samp_cycles;
    logic [7:0] cmp_cycles;
    logic       wr_go;
    logic       wr_mode;
    logic       wr_chan;
    logic       wr_stat;
    logic       wr_ok;
    logic       conv_end;
    logic [9:0] final_val;
    logic       cmp_now;

    // ---------------------------------------------------------------
    // Phase length table
    // ---------------------------------------------------------------
    sas_timing_lut #(
        .SAMP_BASE     (SAMP_BASE),
        .SAMP_STEP     (SAMP_STEP),
        .CMP_BASE      (CMP_BASE),
        .CMP_STEP      (CMP_STEP)
    ) u_lut (
        .i_ref_clk     (i_ref_clk),
        .i_rst         (i_rst),
        .i_time_code   (s_r.mode[sas_pkg::MODE_TIME_LSB +: sas_pkg::MODE_TIME_W]),
        .o_samp_cycles (samp_cycles),
        .o_cmp_cycles  (cmp_cycles)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign o_awready           = !s_r.aw_held && !s_r.bvalid;
    assign o_wready            = !s_r.w_held && !s_r.bvalid;
    assign o_bvalid            = s_r.bvalid;
    assign o_bresp             = s_r.bresp;
    assign o_arready           = !s_r.rvalid;
    assign o_rvalid            = s_r.rvalid;
    assign o_rdata             = s_r.rdata;
    assign o_rresp             = s_r.rresp;
    assign o_comparator_enable = s_r.mode[sas_pkg::MODE_CE_BIT];
    assign o_sample_en         = (s_r.phase == SAS_SAMPLE);
    assign o_channel_select    = s_r.chan;
    assign o_tap_code          = s_r.approximation_register;
    assign o_done_irq          = s_r.irq;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        s_nxt.irq = 1'b0;
        wr_go     = s_r.aw_held && s_r.w_held && !s_r.bvalid;
        wr_ok     = wr_go && s_r.wstrb0;
        wr_mode   = wr_ok && (s_r.awaddr == sas_pkg::MODE_OFS);
        wr_chan   = wr_ok && (s_r.awaddr == sas_pkg::CHAN_OFS);
        wr_stat   = wr_ok && (s_r.awaddr == sas_pkg::STATUS_OFS);
        conv_end  = (s_r.phase == SAS_COMPARE) && (s_r.cnt == 8'h01) && (s_r.bit_idx == 4'h0);
        // A comparator change counts once the two later stages agree. The
        // decision takes that value in the same cycle, so the shortest compare
        // phase still judges its own tap and not the one before it.
        cmp_now   = (s_r.cmp_s2 == s_r.cmp_s3) ? s_r.cmp_s3 : s_r.cmp;
        final_val = s_r.approximation_register;
        final_val[0] = cmp_now;

        // Write channels are held separately and retired together.
        if (i_awvalid && o_awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr  = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata  = i_wdata[7:0];
            s_nxt.wstrb0 = i_wstrb[0];
        end
        if (wr_go) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            unique case (s_r.awaddr)
                sas_pkg::MODE_OFS, sas_pkg::CHAN_OFS, sas_pkg::STATUS_OFS,
                sas_pkg::WIDE_OFS, sas_pkg::NARROW_OFS: s_nxt.bresp = sas_pkg::RESP_OKAY;
                default:                                s_nxt.bresp = sas_pkg::RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Read data are captured from the current registers, so a result
        // update on the same edge is seen only by the next read.
        if (i_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = sas_pkg::RESP_OKAY;
            s_nxt.rdata  = 32'h0000_0000;
            unique case (i_araddr)
                sas_pkg::MODE_OFS:   s_nxt.rdata[7:0]  = s_r.mode;
                sas_pkg::CHAN_OFS:   s_nxt.rdata[2:0]  = s_r.chan;
                sas_pkg::WIDE_OFS:   s_nxt.rdata[15:0] = s_r.wide;
                sas_pkg::NARROW_OFS: s_nxt.rdata[7:0]  = s_r.narrow;
                sas_pkg::STATUS_OFS: begin
                    s_nxt.rdata[sas_pkg::STAT_DONE_BIT] = s_r.flag;
                    s_nxt.rdata[sas_pkg::STAT_BUSY_BIT] = (s_r.phase != SAS_IDLE);
                end
                default:             s_nxt.rresp = sas_pkg::RESP_SLVERR;
            endcase
        end
        if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Comparator decision crosses in from the analog side.
        s_nxt.cmp_s1 = i_comp_ge;
        s_nxt.cmp_s2 = s_r.cmp_s1;
        s_nxt.cmp_s3 = s_r.cmp_s2;
        if (s_r.cmp_s2 == s_r.cmp_s3) begin
            s_nxt.cmp = s_r.cmp_s3;
        end

        // Conversion sequence.
        unique case (s_r.phase)
            SAS_IDLE: begin
                if (s_r.mode[sas_pkg::MODE_START_BIT]) begin
                    s_nxt.phase = SAS_SAMPLE;
                    s_nxt.cnt   = samp_cycles;
                end
            end
            SAS_SAMPLE: begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == 8'h01) begin
                    s_nxt.phase   = SAS_COMPARE;
                    s_nxt.cnt     = cmp_cycles;
                    s_nxt.bit_idx = sas_pkg::MSB_IDX;
                    s_nxt.approximation_register     = sas_pkg::FIRST_TRIAL;
                end
            end
            SAS_COMPARE: begin
                s_nxt.cnt = s_r.cnt - 8'h01;
                if (s_r.cnt == 8'h01) begin
                    s_nxt.approximation_register[s_r.bit_idx] = cmp_now;
                    if (s_r.bit_idx == 4'h0) begin
                        s_nxt.phase = SAS_SAMPLE;
                        s_nxt.cnt   = samp_cycles;
                        if (!(wr_mode || wr_chan)) begin
                            s_nxt.wide   = {final_val, 6'h00};
                            s_nxt.narrow = final_val[9:2];
                            s_nxt.irq    = 1'b1;
                        end
                    end else begin
                        s_nxt.bit_idx                 = s_r.bit_idx - 4'h1;
                        s_nxt.approximation_register[s_r.bit_idx - 4'h1] = 1'b1;
                        s_nxt.cnt                     = cmp_cycles;
                    end
                end
            end
            default: begin
                s_nxt.phase = SAS_IDLE;
            end
        endcase

        // Register writes take effect after the sequence step and win over it, except that a done-flag set wins over a status clear.
        if (wr_mode) begin
            s_nxt.mode = s_r.wdata;
            if (!s_r.wdata[sas_pkg::MODE_START_BIT]) begin
                s_nxt.phase = SAS_IDLE;
            end
        end
        if (wr_chan) begin
            s_nxt.chan = s_r.wdata[sas_pkg::CHAN_W-1:0];
            if (s_r.phase != SAS_IDLE) begin
                s_nxt.phase = s_r.mode[sas_pkg::MODE_START_BIT] ? SAS_SAMPLE : SAS_IDLE;
                s_nxt.cnt   = samp_cycles;
            end
        end
        if (wr_stat && s_r.wdata[sas_pkg::STAT_DONE_BIT]) begin
            s_nxt.flag = 1'b0;
        end
        if (s_nxt.irq) begin
            s_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_r        <= '0;
            s_r.mode   <= sas_pkg::MODE_RST;
            s_r.chan   <= sas_pkg::CHAN_RST;
            s_r.wide   <= sas_pkg::WIDE_RST;
            s_r.narrow <= sas_pkg::NARROW_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    stopped_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !s_r.mode[sas_pkg::MODE_START_BIT] |-> s_r.phase == SAS_IDLE)
        else $error("Sequencer runs with start bit clear.");

    wide_justify_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_r.wide[5:0] == 6'h00)
        else $error("Wide result low bits not zero.");

    narrow_match_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_r.narrow == s_r.wide[15:8])
        else $error("Narrow result differs from wide upper byte.");

    irq_store_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        conv_end && !(wr_mode || wr_chan) |=> o_done_irq && s_r.flag && s_r.wide == {$past(final_val), 6'h00})
        else $error("Result or interrupt missing at conversion end.");

    first_trial_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_r.phase == SAS_SAMPLE ##1 s_r.phase == SAS_COMPARE |-> o_tap_code == sas_pkg::FIRST_TRIAL)
        else $error("First trial is not half reference.");

    hold_phase_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_r.phase == SAS_COMPARE |-> !o_sample_en && s_r.bit_idx <= sas_pkg::MSB_IDX)
        else $error("Sampling during comparison.");

    chan_abort_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_chan && s_r.phase != SAS_IDLE && s_r.mode[sas_pkg::MODE_START_BIT] && !wr_mode
        |=> s_r.phase == SAS_SAMPLE && !o_done_irq)
        else $error("Channel write did not restart sampling.");

    write_wins_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        conv_end && (wr_mode || wr_chan) |=> !o_done_irq && $stable(s_r.wide))
        else $error("Result stored despite coinciding register write.");

    flag_set_wins_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_done_irq |-> s_r.flag)
        else $error("Done flag lost at interrupt.");

    start_go_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_r.phase == SAS_IDLE && s_r.mode[sas_pkg::MODE_START_BIT] && !wr_mode && !wr_chan
        |=> s_r.phase == SAS_SAMPLE)
        else $error("Start bit did not begin sampling.");

    trial_bit_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_r.phase == SAS_COMPARE && s_r.cnt == 8'h01 && s_r.bit_idx != 4'h0 && !wr_mode && !wr_chan
        |=> s_r.phase == SAS_COMPARE && o_tap_code[s_r.bit_idx] == 1'b1)
        else $error("Next trial bit not set after a decision.");

    reset_clear_a: assert property (@(posedge i_ref_clk)
        $fell(i_rst) |-> s_r.wide == 16'h0000 && s_r.narrow == 8'h00 && o_channel_select == 3'h0)
        else $error("Result or channel registers not cleared by reset.");

    auto_repeat_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        conv_end |=> s_r.phase == (s_r.mode[sas_pkg::MODE_START_BIT] ? SAS_SAMPLE : SAS_IDLE))
        else $error("Next conversion did not follow at once.");

endmodule // sas_sequencer

// file: tb/sas_analog_model.sv
// Behavioural sample-and-hold and comparator on the far side of the converter sequencer.
`timescale 1ns/100ps

module sas_analog_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sample_en,
    input  wire logic [2:0]  i_channel,
    input  wire logic [9:0]  i_tap,
    input  wire logic [59:0] i_levels,
    output logic             o_comp_ge
);
    logic [9:0] held_r;

    initial held_r = 10'h000;
    // The selected input is tracked while sampling and frozen otherwise.
    always @(posedge i_ref_clk) begin
        if (i_sample_en) held_r <= i_levels[i_channel*10 +: 10];
    end
    // An input equal to the tap reads as at or above it.
    assign o_comp_ge = (held_r >= i_tap);
endmodule // sas_analog_model

// file: tb/tb_top.sv
// Self-checking testbench of the converter sequencer with its analog partner.
`timescale 1ns/100ps

module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'hF;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [59:0] levels  = {10'h15A, 10'h2A5, 10'h1FF, 10'h200, 10'h3FF, 10'h000};
    logic        awready, wready, bvalid, arready, rvalid, comp_ge, ce, samp, irq;
    logic [1:0]  bresp, rresp, resp_v;
    logic [31:0] rdata, rd_v;
    logic [2:0]  chan;
    logic [9:0]  tap;
    int          fails = 0;
    int          check_count = 0;
    int          n, per0;
    int          irq_cnt = 0;

    always #5 ref_clk = ~ref_clk;

    // Counts every end-of-conversion pulse, so a pulse that a task cannot watch is still seen.
    always @(posedge ref_clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

    sas_sequencer sas_sequencer_i (.i_ref_clk(ref_clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_comp_ge(comp_ge), .o_comparator_enable(ce), .o_sample_en(samp), .o_channel_select(chan),
        .o_tap_code(tap), .o_done_irq(irq));

    sas_analog_model sas_analog_model_i (.i_ref_clk(ref_clk), .i_sample_en(samp), .i_channel(chan),
        .i_tap(tap), .i_levels(levels), .o_comp_ge(comp_ge));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_d, w_d, ok;
        aw_d = 1'b0;
        w_d  = 1'b0;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge ref_clk);
            ok   = !aw_d && awready;
            w_d  = w_d || wready;
            @(posedge ref_clk);
            if (ok) awvalid <= 1'b0;
            if (w_d) wvalid <= 1'b0;
            aw_d = aw_d || ok;
        end while (!(aw_d && w_d));
        do begin
            @(negedge ref_clk);
            ok   = bvalid;
            resp = bresp;
            @(posedge ref_clk);
        end while (!ok);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ok;
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge ref_clk);
            ok = arready;
            @(posedge ref_clk);
        end while (!ok);
        arvalid <= 1'b0;
        do begin
            @(negedge ref_clk);
            ok   = rvalid;
            d    = rdata;
            resp = rresp;
            @(posedge ref_clk);
        end while (!ok);
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd(a, rd_v, resp_v);
        chk(what, exp, rd_v);
    endtask

    task automatic wait_irq(output int cyc);
        cyc = 0;
        do begin
            @(negedge ref_clk);
            cyc++;
        end while (irq !== 1'b1);
    endtask

    task automatic t_reset();
        rchk(sas_pkg::WIDE_OFS, 32'h0, "wide result");
        rchk(sas_pkg::NARROW_OFS, 32'h0, "narrow result");
        rchk(sas_pkg::CHAN_OFS, 32'h0, "channel select");
        rchk(sas_pkg::MODE_OFS, 32'h0, "mode");
        rd(8'h20, rd_v, resp_v);
        chk("unmapped read response", {30'h0, sas_pkg::RESP_SLVERR}, {30'h0, resp_v});
        wr(8'h20, 32'h1, resp_v);
        chk("unmapped write response", {30'h0, sas_pkg::RESP_SLVERR}, {30'h0, resp_v});
        $display("test reset values done");
    endtask

    task automatic t_channels();
        logic [9:0] v;
        wr(sas_pkg::MODE_OFS, 32'h01, resp_v);
        chk("comparator enable", 32'h1, {31'h0, ce});
        repeat (100) @(posedge ref_clk);
        wr(sas_pkg::MODE_OFS, 32'h81, resp_v);
        for (int c = 0; c < 6; c++) begin
            v = levels[c*10 +: 10];
            wr(sas_pkg::CHAN_OFS, 32'(c), resp_v);
            wait_irq(n);
            chk("channel output", 32'(c), {29'h0, chan});
            rchk(sas_pkg::WIDE_OFS, {16'h0, v, 6'h00}, "wide result");
            rchk(sas_pkg::NARROW_OFS, {24'h0, v[9:2]}, "narrow result");
        end
        rchk(sas_pkg::STATUS_OFS, 32'h3, "status while running");
        $display("test channel conversions done");
    endtask

    task automatic t_timing();
        logic [7:0] mv [3] = '{8'h83, 8'h89, 8'hC1};
        int         inc [3] = '{20, 4, 32};
        wait_irq(n);
        wait_irq(per0);
        wait_irq(n);
        chk("repeat period", 32'(per0), 32'(n));
        wr(sas_pkg::CHAN_OFS, 32'h4, resp_v);
        wait_irq(n);
        chk("span after channel change", 32'h1, {31'h0, (n + 1 >= per0 - 2) && (n + 1 <= per0 + 2)});
        for (int k = 0; k < 3; k++) begin
            wr(sas_pkg::MODE_OFS, {24'h0, mv[k]}, resp_v);
            wait_irq(n);
            wait_irq(n);
            chk("period for time code", 32'(per0 + inc[k]), 32'(n));
        end
        wr(sas_pkg::MODE_OFS, 32'h81, resp_v);
        $display("test conversion timing done");
    endtask

    task automatic t_stop();
        int seen;
        int base;
        seen = 0;
        wait_irq(n);
        // A write takes effect three edges after the task starts, so this lands on the conversion end.
        repeat (per0 - 3) @(posedge ref_clk);
        base = irq_cnt;
        wr(sas_pkg::CHAN_OFS, 32'h4, resp_v);
        wait_irq(n);
        chk("pulses at write collision", 32'(base), 32'(irq_cnt));
        chk("span after collision", 32'(per0), 32'(n));
        repeat (10) @(posedge ref_clk);
        wr(sas_pkg::MODE_OFS, 32'h01, resp_v);
        repeat (300) begin
            @(negedge ref_clk);
            if (irq !== 1'b0) seen++;
        end
        chk("pulses after stop", 32'h0, 32'(seen));
        rchk(sas_pkg::WIDE_OFS, {16'h0, levels[40 +: 10], 6'h00}, "kept result");
        rchk(sas_pkg::STATUS_OFS, 32'h1, "status after stop");
        wr(sas_pkg::CHAN_OFS, 32'h2, resp_v);
        rchk(sas_pkg::STATUS_OFS, 32'h1, "flag after channel write");
        wr(sas_pkg::STATUS_OFS, 32'h1, resp_v);
        rchk(sas_pkg::STATUS_OFS, 32'h0, "flag after clear");
        wr(sas_pkg::WIDE_OFS, 32'hFFFF, resp_v);
        chk("result write response", {30'h0, sas_pkg::RESP_OKAY}, {30'h0, resp_v});
        rchk(sas_pkg::WIDE_OFS, {16'h0, levels[40 +: 10], 6'h00}, "read-only result");
        wr(sas_pkg::MODE_OFS, 32'h00, resp_v);
        chk("comparator disable", 32'h0, {31'h0, ce});
        $display("test stop and flag done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_channels();
        t_timing();
        t_stop();
        wrap_up();
    end
endmodule // tb_top
